// ---- bench/can_bus_node_model.sv ----
/*
 far-side model: another node sending one frame on request.
 assumes start is a one-cycle pulse on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module can_bus_node_model #(
   parameter int FRAME_LEN = 12
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic give_ack,
   output logic bus_active,
   output logic ack_seen,
   output logic frame_ok
);
   int cnt;
   always_ff @(posedge sys_clk) begin
      if (reset)
         cnt <= 0;
      else if (start)
         cnt <= FRAME_LEN;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
   // bus stays recessive between frames
   assign bus_active = (cnt != 0);
   assign frame_ok = (cnt == 1);
   assign ack_seen = (cnt == 1) && give_ack;
endmodule
`default_nettype wire

// ---- bench/tb_can_mode_and_irq_enable.sv ----
/*
 testbench for the can mode and interrupt-enable control.
 assumes the register map and field values of can_mode_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_can_mode_and_irq_enable
   import can_mode_pkg::*;
   ;
   logic sys_clk, reset, clk_en, reg_write, reg_read, mstart, give_ack;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic bus_active, ack_seen, frame_ok, tx_success, ack_drive, error_count_freeze, irq;
   core_events_t events;
   mode_ctl_t mode_ctl;
   int mismatches = 0;
   int compares = 0;
   localparam logic [9:0] ev_row [7] = '{10'h200, 10'h100, 10'h080, 10'h020,
      10'h010, 10'h008, 10'h004};
   localparam logic [7:0] src_row [7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h04, 8'h02};
   can_mode_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .events(events),
      .bus_activity_pin(bus_active), .ack_received(ack_seen), .rx_frame_ok(frame_ok),
      .tx_success(tx_success), .ack_drive(ack_drive),
      .error_count_freeze(error_count_freeze), .mode_ctl(mode_ctl), .irq(irq));
   can_bus_node_model node (.sys_clk(sys_clk), .reset(reset), .start(mstart),
      .give_ack(give_ack), .bus_active(bus_active), .ack_seen(ack_seen),
      .frame_ok(frame_ok));
   always #10 sys_clk = ~sys_clk;
   // ==========================================================
   // tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic ev(input logic [9:0] m);
      @(posedge sys_clk);
      events <= core_events_t'(m);
      @(posedge sys_clk);
      events <= '0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic go(input logic ack);
      @(posedge sys_clk);
      give_ack <= ack;
      mstart <= 1'b1;
      @(posedge sys_clk);
      mstart <= 1'b0;
   endtask
   task automatic frame(input logic ack, input logic exp_drive, input logic exp_tx);
      go(ack);
      for (int k = 0; k < 20 && frame_ok !== 1'b1; k++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(ack_drive, exp_drive);
      chk(tx_success, exp_tx);
   endtask
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // watchdog
   initial begin
      #(20 * 5000);
      mismatches++;
      $display("mismatch at %0t ns: watchdog expired", $time);
      end_of_test;
   end
   // ==========================================================
   // tests
   initial begin
      sys_clk = 0;
      reset = 1;
      clk_en = 1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 0;
      reg_read = 0;
      events = '0;
      mstart = 0;
      give_ack = 1;
      repeat (16) @(posedge sys_clk);
      reset <= 0;
      rd(OPERATING_CONFIG_ADDR, 8'h01);
      rd(IRQ_ENABLE_MASK_ADDR, 8'h00);
      rd(MODE_STATE_ADDR, 8'h01);
      wr(IRQ_ENABLE_MASK_ADDR, 8'hA5);
      rd(IRQ_ENABLE_MASK_ADDR, 8'hA5);
      rd(8'h10, 8'h00);
      wr(OPERATING_CONFIG_ADDR, 8'h11);
      rd(OPERATING_CONFIG_ADDR, 8'h01);
      wr(OPERATING_CONFIG_ADDR, 8'h00);
      rd(MODE_STATE_ADDR, 8'h02);
      $display("test reset and access done");
      for (int i = 0; i < 7; i++) begin
         wr(IRQ_ENABLE_MASK_ADDR, src_row[i]);
         ev(ev_row[i]);
         chk(irq, 1);
         rd(IRQ_SOURCE_ADDR, src_row[i]);
         rd(IRQ_SOURCE_ADDR, 8'h00);
         wr(IRQ_ENABLE_MASK_ADDR, ~src_row[i]);
         ev(ev_row[i]);
         rd(IRQ_SOURCE_ADDR, 8'h00);
         chk(irq, 0);
      end
      wr(IRQ_ENABLE_MASK_ADDR, 8'h01);
      ev(10'h002);
      rd(IRQ_SOURCE_ADDR, 8'h01);
      rd(IRQ_SOURCE_ADDR, 8'h01);
      ev(10'h001);
      rd(IRQ_SOURCE_ADDR, 8'h00);
      $display("test event rows done");
      wr(OPERATING_CONFIG_ADDR, 8'hEC);
      rd(OPERATING_CONFIG_ADDR, 8'h0C);
      chk(mode_ctl.dual_filter, 0);
      frame(0, 1, 1);
      wr(OPERATING_CONFIG_ADDR, 8'h02);
      chk(mode_ctl.dual_filter, 1);
      chk(error_count_freeze, 1);
      frame(1, 0, 1);
      wr(OPERATING_CONFIG_ADDR, 8'h00);
      frame(0, 1, 0);
      $display("test mode bits done");
      wr(IRQ_ENABLE_MASK_ADDR, 8'h10);
      go(1);
      repeat (4) @(posedge sys_clk);
      wr(OPERATING_CONFIG_ADDR, 8'h10);
      repeat (3) @(posedge sys_clk);
      rd(MODE_STATE_ADDR, 8'h02);
      rd(IRQ_SOURCE_ADDR, 8'h10);
      repeat (20) @(posedge sys_clk);
      wr(OPERATING_CONFIG_ADDR, 8'h10);
      repeat (3) @(posedge sys_clk);
      rd(MODE_STATE_ADDR, 8'h04);
      rd(OPERATING_CONFIG_ADDR, 8'h10);
      wr(OPERATING_CONFIG_ADDR, 8'h00);
      repeat (3) @(posedge sys_clk);
      rd(MODE_STATE_ADDR, 8'h02);
      rd(IRQ_SOURCE_ADDR, 8'h10);
      $display("test sleep done");
      wr(OPERATING_CONFIG_ADDR, 8'h01);
      chk(mode_ctl.abort_frame, 1);
      rd(MODE_STATE_ADDR, 8'h01);
      $display("test reset mode done");
      end_of_test;
   end
endmodule
`default_nettype wire

// ---- hw/can_mode_ctrl.sv ----
/*
 mode register, interrupt-enable register and interrupt source flags
 of a can controller. assumes events come from logic on sys_clk, and
 bus_activity_pin comes straight from the bus receiver pin.
*/
// Functional notes
// - bus fault raises interrupt when enabled
// - arbitration loss raises interrupt when enabled
// - passive state change raises interrupt if enabled
// - wake from sleep raises interrupt when enabled
// - overrun flag rise raises interrupt when enabled
// - bus or error status change interrupt
// - transmit done raises interrupt when enabled
// - receive full level raises interrupt when enabled
// - enable register readable, writable, per-bit gating
// - mode register rw, top three bits zero
// - sleep bit writable only in operating mode
// - sleep only when idle and nothing pending
// - activity or pending interrupt forces wake-up
// - clearing sleep bit wakes the controller
// - filter bit selects single or dual filter
// - self test accepts missing acknowledge
// - listen-only never drives acknowledge
// - listen-only freezes the error counters
// - reset bit aborts frame, enters reset
// - leave reset on one-to-zero transition
// - interrupt output high while any flag set
// - source read clears all but receive flag
`timescale 1ns/1ps
`default_nettype none
module can_mode_ctrl
   import can_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire core_events_t events,
   input wire logic bus_activity_pin,
   input wire logic ack_received,
   input wire logic rx_frame_ok,
   output logic tx_success,
   output logic ack_drive,
   output logic error_count_freeze,
   output mode_ctl_t mode_ctl,
   output logic irq
);
   // ==========================================================
   // register state
   logic [7:0] operating_config;
   logic [7:0] irq_enable_mask;
   logic [7:0] irq_source;
   logic [7:0] prev_levels;
   mode_state_t state;
   mode_state_t next_state;
   logic act_meta;
   logic act_sync;
   logic act_prev;

   // ==========================================================
   // decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction
   wire wr_cfg = clk_en && reg_write && hit(reg_addr, OPERATING_CONFIG_ADDR);
   wire wr_ier = clk_en && reg_write && hit(reg_addr, IRQ_ENABLE_MASK_ADDR);
   wire rd_src = clk_en && reg_read && hit(reg_addr, IRQ_SOURCE_ADDR);
   wire in_reset = operating_config[CFG_RESET];
   wire pending = |irq_source;
   wire activity_rise = act_sync && !act_prev;
   wire sleep_bit = operating_config[CFG_SLEEP];

   // ==========================================================
   // mode register write
   logic [7:0] next_cfg;
   wire next_sleep = in_reset ? sleep_bit : reg_wdata[CFG_SLEEP];
   assign next_cfg = {3'b000, next_sleep, reg_wdata[3:0]} & CFG_RESERVED_MASK;

   // ==========================================================
   // sleep and mode state
   // enter sleep only idle
   wire can_sleep = sleep_bit && !pending && !act_sync;
   wire wake_cond = !sleep_bit || activity_rise || pending;
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET: begin
            if (!in_reset) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (in_reset) begin
               next_state = ST_RESET;
            end else if (can_sleep) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (in_reset) begin
               next_state = ST_RESET;
            end else if (wake_cond) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RESET;
      endcase
   end
   wire woke = (state == ST_SLEEP) && (next_state == ST_RUN);
   wire sleep_refused = (state == ST_RUN) && (pending || act_sync) && !in_reset
      && wr_cfg && reg_wdata[CFG_SLEEP];
   wire wake_evt = woke || sleep_refused;

   // ==========================================================
   // width check
   if (REG_W != 8) begin : width_check
      $error("register width must be 8");
   end

   // ==========================================================
   // interrupt source flags
   logic [7:0] raw_evt;
   logic [7:0] levels;
   assign levels = {5'b00000, events.overrun_flag, events.bus_status, events.error_status};
   assign raw_evt[IRQ_BUS_FAULT] = events.bus_fault;
   assign raw_evt[IRQ_ARB_LOSS] = events.arb_loss;
   assign raw_evt[IRQ_PASSIVE] = events.passive_change;
   assign raw_evt[IRQ_WAKE] = wake_evt;
   assign raw_evt[IRQ_OVERRUN] = events.overrun_flag && !prev_levels[2];
   assign raw_evt[IRQ_WARNING] = (events.bus_status ^ prev_levels[1])
      || (events.error_status ^ prev_levels[0]);
   assign raw_evt[IRQ_TRANSMIT] = events.tx_released;
   assign raw_evt[IRQ_RECEIVE] = events.rx_full;
   wire [7:0] set_evt = raw_evt & irq_enable_mask;
   wire [7:0] clr_evt = (rd_src ? ~IRQ_KEEP_ON_READ : 8'h00)
      | {7'h00, events.rx_released_empty};
   // set wins over clear
   wire [7:0] next_source = set_evt | (irq_source & ~clr_evt);

   // ==========================================================
   // read mux
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (reg_read) begin
         unique case (reg_addr)
            OPERATING_CONFIG_ADDR: next_rdata = operating_config;
            IRQ_ENABLE_MASK_ADDR: next_rdata = irq_enable_mask;
            IRQ_SOURCE_ADDR: next_rdata = irq_source;
            MODE_STATE_ADDR: next_rdata = {5'b00000, state};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // flops
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         operating_config <= CFG_RESET_VALUE;
         irq_enable_mask <= IRQ_RESET_VALUE;
         irq_source <= 8'h00;
         prev_levels <= 8'h00;
         state <= ST_RESET;
         act_meta <= 1'b0;
         act_sync <= 1'b0;
         act_prev <= 1'b0;
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         act_meta <= bus_activity_pin;
         act_sync <= act_meta;
         act_prev <= act_sync;
         if (wr_cfg) begin
            operating_config <= next_cfg;
         end
         if (wake_evt) begin
            operating_config[CFG_SLEEP] <= 1'b0;
         end
         if (wr_ier) begin
            irq_enable_mask <= reg_wdata;
         end
         irq_source <= next_source;
         prev_levels <= levels;
         state <= next_state;
         reg_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // outputs
   // interrupt output
   assign irq = |irq_source;
   assign mode_ctl.abort_frame = in_reset;
   assign mode_ctl.reset_active = (state == ST_RESET);
   assign mode_ctl.sleeping = (state == ST_SLEEP);
   assign mode_ctl.dual_filter = !operating_config[CFG_FILTER];
   assign mode_ctl.self_test = operating_config[CFG_SELF_TEST];
   assign mode_ctl.listen_only = operating_config[CFG_LISTEN];
   assign tx_success = ack_received || operating_config[CFG_SELF_TEST];
   assign ack_drive = rx_frame_ok && !operating_config[CFG_LISTEN] && !in_reset;
   assign error_count_freeze = operating_config[CFG_LISTEN];

   // ==========================================================
   // checks
   irq_level_a: assert property (@(posedge sys_clk) disable iff (reset)
      irq == (irq_source != 8'h00)) else $error("irq not tied to flags");
   cfg_reserved_a: assert property (@(posedge sys_clk) disable iff (reset)
      operating_config[7:5] == 3'b000) else $error("reserved mode bits set");
   sleep_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && in_reset && wr_cfg |=> $stable(operating_config[CFG_SLEEP]))
      else $error("sleep written in reset mode");
   bus_fault_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.bus_fault && irq_enable_mask[IRQ_BUS_FAULT] |=> irq_source[IRQ_BUS_FAULT])
      else $error("bus fault flag missing");
   arb_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && !irq_source[IRQ_ARB_LOSS] && !irq_enable_mask[IRQ_ARB_LOSS]
      |=> !irq_source[IRQ_ARB_LOSS]) else $error("arbitration flag while disabled");
   rx_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && rd_src && irq_source[IRQ_RECEIVE] && !events.rx_released_empty
      |=> irq_source[IRQ_RECEIVE]) else $error("receive flag lost on read");
   read_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && rd_src && !events.arb_loss |=> !irq_source[IRQ_ARB_LOSS])
      else $error("source read did not clear");
   sleep_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state == ST_RUN && pending |=> state != ST_SLEEP)
      else $error("slept with interrupt pending");
   reset_exit_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state == ST_RESET && !in_reset |=> state == ST_RUN)
      else $error("reset mode not left");
   listen_ack_a: assert property (@(posedge sys_clk) disable iff (reset)
      operating_config[CFG_LISTEN] |-> !ack_drive) else $error("ack in listen only");

   arb_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.arb_loss && irq_enable_mask[IRQ_ARB_LOSS]
      |=> irq_source[IRQ_ARB_LOSS])
      else $error("arbitration flag missing");

   passive_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.passive_change && irq_enable_mask[IRQ_PASSIVE]
      |=> irq_source[IRQ_PASSIVE])
      else $error("passive flag missing");

   wake_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && wake_evt && irq_enable_mask[IRQ_WAKE]
      |=> irq_source[IRQ_WAKE])
      else $error("wake flag missing");

   overrun_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.overrun_flag && !prev_levels[2] && irq_enable_mask[IRQ_OVERRUN]
      |=> irq_source[IRQ_OVERRUN])
      else $error("overrun flag missing");

   warning_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && (events.bus_status != prev_levels[1]) && irq_enable_mask[IRQ_WARNING]
      |=> irq_source[IRQ_WARNING])
      else $error("warning flag missing");

   transmit_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.tx_released && irq_enable_mask[IRQ_TRANSMIT]
      |=> irq_source[IRQ_TRANSMIT])
      else $error("transmit flag missing");

   receive_on_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && events.rx_full && irq_enable_mask[IRQ_RECEIVE]
      |=> irq_source[IRQ_RECEIVE])
      else $error("receive flag missing");

   for (genvar g = 0; g < REG_W; g++) begin : gate_chk
      gate_off_a: assert property (@(posedge sys_clk) disable iff (reset)
         clk_en && !irq_enable_mask[g] && !irq_source[g]
         |=> !irq_source[g])
         else $error("flag set while disabled");
      gate_on_a: assert property (@(posedge sys_clk) disable iff (reset)
         clk_en && set_evt[g]
         |=> irq_source[g])
         else $error("enabled event lost");
   end

   enable_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_ier
      |=> irq_enable_mask == $past(reg_wdata))
      else $error("enable write lost");

   rdata_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && !reg_read
      |=> reg_rdata == 8'h00)
      else $error("read data without read");

   cfg_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_cfg
      |=> operating_config[3:0] == $past(reg_wdata[3:0]))
      else $error("mode write lost");

   sleep_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_cfg && !in_reset && !reg_wdata[CFG_SLEEP]
      |=> !operating_config[CFG_SLEEP])
      else $error("sleep clear lost");

   sleep_activity_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state == ST_RUN && act_sync
      |=> state != ST_SLEEP)
      else $error("slept with bus activity");

   refuse_wake_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && sleep_refused
      |=> !operating_config[CFG_SLEEP] && state != ST_SLEEP)
      else $error("refused sleep not woken");

   wake_on_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state == ST_SLEEP && !sleep_bit && !in_reset
      |=> state == ST_RUN)
      else $error("no wake on sleep clear");

   filter_map_a: assert property (@(posedge sys_clk) disable iff (reset)
      operating_config[CFG_FILTER]
      |-> !mode_ctl.dual_filter)
      else $error("filter layout wrong");

   self_test_a: assert property (@(posedge sys_clk) disable iff (reset)
      operating_config[CFG_SELF_TEST]
      |-> tx_success)
      else $error("self test not successful");

   ack_need_a: assert property (@(posedge sys_clk) disable iff (reset)
      !operating_config[CFG_SELF_TEST] && !ack_received
      |-> !tx_success)
      else $error("success without acknowledge");

   freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
      operating_config[CFG_LISTEN]
      |-> error_count_freeze)
      else $error("counters not frozen");

   abort_a: assert property (@(posedge sys_clk) disable iff (reset)
      wr_cfg && reg_wdata[CFG_RESET]
      |=> mode_ctl.abort_frame)
      else $error("frame not aborted");

   reset_enter_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && in_reset && state != ST_RESET
      |=> state == ST_RESET)
      else $error("reset mode not entered");

   source_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && rd_src && !events.bus_fault
      |=> !irq_source[IRQ_BUS_FAULT])
      else $error("bus fault flag kept on read");

   reset_value_a: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(reset)
      |-> operating_config == CFG_RESET_VALUE && irq_enable_mask == IRQ_RESET_VALUE)
      else $error("wrong values after reset");
endmodule
`default_nettype wire

// ---- inc/can_mode_pkg.sv ----
/*
 package for the can mode and interrupt-enable control block.
 assumes a plain register port with 8-bit data in the low bits.
*/
package can_mode_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] OPERATING_CONFIG_ADDR = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_MASK_ADDR = 8'h04;
   localparam logic [7:0] IRQ_SOURCE_ADDR = 8'h08;
   localparam logic [7:0] MODE_STATE_ADDR = 8'h0C;
   localparam int REG_W = 8;
   // ==========================================================
   // field positions
   localparam int CFG_SLEEP = 4;
   localparam int CFG_FILTER = 3;
   localparam int CFG_SELF_TEST = 2;
   localparam int CFG_LISTEN = 1;
   localparam int CFG_RESET = 0;
   localparam int IRQ_BUS_FAULT = 7;
   localparam int IRQ_ARB_LOSS = 6;
   localparam int IRQ_PASSIVE = 5;
   localparam int IRQ_WAKE = 4;
   localparam int IRQ_OVERRUN = 3;
   localparam int IRQ_WARNING = 2;
   localparam int IRQ_TRANSMIT = 1;
   localparam int IRQ_RECEIVE = 0;
   localparam logic [7:0] CFG_RESERVED_MASK = 8'h1F;
   localparam logic [7:0] CFG_RESET_VALUE = 8'h01;
   localparam logic [7:0] IRQ_RESET_VALUE = 8'h00;
   localparam logic [7:0] IRQ_KEEP_ON_READ = 8'h01;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_RUN = 3'b010,
      ST_SLEEP = 3'b100
   } mode_state_t;
   typedef struct packed {
      logic bus_fault;
      logic arb_loss;
      logic passive_change;
      logic bus_activity;
      logic overrun_flag;
      logic bus_status;
      logic error_status;
      logic tx_released;
      logic rx_full;
      logic rx_released_empty;
   } core_events_t;
   typedef struct packed {
      logic reset_active;
      logic sleeping;
      logic dual_filter;
      logic self_test;
      logic listen_only;
      logic abort_frame;
   } mode_ctl_t;
endpackage
